// ### verilog/vpic_cfg.svh
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH

// register byte addresses on the avalon slave
`define VPIC_OFS_GCTL1      8'h00
`define VPIC_OFS_GCTL2      8'h04
`define VPIC_OFS_STATUS     8'h08
`define VPIC_OFS_CORE       8'h0C
`define VPIC_OFS_SNAP       8'h10
`define VPIC_OFS_FLAG0      8'h20
`define VPIC_OFS_ENAB0      8'h40
`define VPIC_OFS_PRIO0      8'h80

// geometry
`define VPIC_NUM_FLAG_REGS  5
`define VPIC_NUM_PRIO_REGS  21
`define VPIC_NUM_SRC        80
`define VPIC_NUM_EXT        3

// unimplemented priority register numbers
`define VPIC_PRIO_HOLE_A    5'h0D
`define VPIC_PRIO_HOLE_B    5'h0E
`define VPIC_PRIO_HOLE_C    5'h11

// vectors fed by the external pins
`define VPIC_EXT0_VEC       7'h00
`define VPIC_EXT1_VEC       7'h14
`define VPIC_EXT2_VEC       7'h1D

// field positions
`define VPIC_NEST_DIS_BIT   15
`define VPIC_ALT_SEL_BIT    15
`define VPIC_LEVEL_LSB      5
`define VPIC_TOP_BIT        3
`define VPIC_TRAP_LSB       1
`define VPIC_SNAP_LVL_LSB   8

// implemented bits of each priority register and of the trap field
`define VPIC_PRIO_MASK      16'h7777
`define VPIC_TRAP_MASK      16'h001E

// vector table placement
`define VPIC_TABLE_BASE     24'h000014
`define VPIC_ALT_OFFSET     24'h000100

// reset values
`define VPIC_RST_WORD       16'h0000
`define VPIC_RST_LEVEL      3'h0

`endif

// ### verilog/vpic_pkg.sv
package vpic_pkg;
	typedef logic [15:0] vpic_word_t;   // one 16-bit register
	typedef logic [2:0]  vpic_prio_t;   // one priority field
	typedef logic [3:0]  vpic_level_t;  // four-bit cpu level
	typedef logic [6:0]  vpic_vec_t;    // vector number
	typedef logic [23:0] vpic_addr_t;   // program address
endpackage

// ### verilog/vpic_arbiter.sv
`timescale 1ns/1ps
`include "vpic_cfg.svh"

// picks the winning source: highest priority, lowest vector on ties
module vpic_arbiter (
	input  wire logic [`VPIC_NUM_SRC-1:0]   pend_i,
	input  wire logic [`VPIC_NUM_SRC-1:0]   enab_i,
	input  wire logic [`VPIC_NUM_SRC*3-1:0] prio_i,
	input  wire vpic_pkg::vpic_level_t      level_i,
	output logic                            found_o,
	output vpic_pkg::vpic_vec_t             vec_o,
	output vpic_pkg::vpic_prio_t            prio_o
);
	// scan in rising vector order
	always_comb begin
		found_o = 1'b0;
		vec_o   = 7'h00;
		prio_o  = 3'h0;
		for (int i = 0; i < `VPIC_NUM_SRC; i++) begin
			if (pend_i[i] && enab_i[i] && ({1'b0, prio_i[i*3 +: 3]} > level_i)) begin
				// zero never beats the start value
				if (prio_i[i*3 +: 3] > prio_o) begin
					found_o = 1'b1;
					vec_o   = 7'(i);
					prio_o  = prio_i[i*3 +: 3];
				end
			end
		end
	end
endmodule

// ### verilog/vpic_ctrl.sv
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "vpic_cfg.svh"

module vpic_ctrl (
	input  wire logic                      SYS_CLK_I,
	input  wire logic                      RESET_N_I,
	// avalon-mm slave
	input  wire logic [7:0]                AVS_ADDRESS_I,
	input  wire logic                      AVS_READ_I,
	input  wire logic                      AVS_WRITE_I,
	input  wire logic [31:0]               AVS_WRITEDATA_I,
	input  wire logic [3:0]                AVS_BYTEENABLE_I,
	output logic [31:0]                    AVS_READDATA_O,
	output logic                           AVS_WAITREQUEST_O,
	// event pulses from peripherals, one bit per vector
	input  wire logic [`VPIC_NUM_SRC-1:0]  SRC_EVENT_I,
	// external interrupt pins, asynchronous
	input  wire logic [`VPIC_NUM_EXT-1:0]  EXT_PIN_I,
	// trap status pulses: math, address, stack, oscillator
	input  wire logic [3:0]                TRAP_EVENT_I,
	// pulse from cpu when it enters trap context
	input  wire logic                      TRAP_ENTER_I,
	// cpu side
	input  wire logic                      IRQ_ACK_I,
	output logic                           IRQ_REQ_O,
	output vpic_pkg::vpic_vec_t            IRQ_VECTOR_O,
	output vpic_pkg::vpic_prio_t           IRQ_PRIO_O,
	output vpic_pkg::vpic_addr_t           IRQ_FETCH_ADDR_O,
	output vpic_pkg::vpic_level_t          CPU_LEVEL_O
);
	// merge a 16-bit register with write data under byte enables
	function automatic vpic_pkg::vpic_word_t merge16(input vpic_pkg::vpic_word_t old_v,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
	endfunction

	// table address of a vector; both tables share one layout
	function automatic vpic_pkg::vpic_addr_t vec_addr(input vpic_pkg::vpic_vec_t v, input logic alt);
		vec_addr = `VPIC_TABLE_BASE + {16'h0000, v, 1'b0};
		if (alt) begin
			vec_addr = vec_addr + `VPIC_ALT_OFFSET;
		end
	endfunction

	// register state
	vpic_pkg::vpic_word_t  flag_q [`VPIC_NUM_FLAG_REGS];  // request flags
	vpic_pkg::vpic_word_t  enab_q [`VPIC_NUM_FLAG_REGS];  // source enables
	vpic_pkg::vpic_word_t  prio_q [`VPIC_NUM_PRIO_REGS];  // priority fields
	logic                  nest_dis_q;                    // nesting disable
	logic [3:0]            trap_q;                        // trap status flags
	logic                  alt_sel_q;                     // alternate table select
	logic [2:0]            edge_pol_q;                    // external pin polarities
	logic [2:0]            level_q;                       // cpu level field
	logic                  top_q;                         // trap-context level bit
	vpic_pkg::vpic_vec_t   snap_vec_q;                    // snapshot vector
	vpic_pkg::vpic_level_t snap_lvl_q;                    // snapshot level
	// bus state
	logic                  ack_q;                         // one-cycle answer
	logic [31:0]           rdata_q;                       // read data
	// pin synchronisers and edge history
	logic [2:0]            pin_m_q;                       // first stage only
	logic [2:0]            pin_s_q;                       // second stage
	logic [2:0]            pin_p_q;                       // previous synced level
	// cpu outputs
	logic                  req_q;
	vpic_pkg::vpic_vec_t   vec_q;
	vpic_pkg::vpic_prio_t  win_prio_q;
	vpic_pkg::vpic_addr_t  fetch_q;

	// bus decode
	wire        bus_req   = AVS_READ_I | AVS_WRITE_I;
	wire        wr_go     = AVS_WRITE_I & ack_q;
	wire [5:0]  word_idx  = AVS_ADDRESS_I[7:2];
	wire [4:0]  prio_idx  = 5'(AVS_ADDRESS_I[6:2]);
	wire        hit_g1    = AVS_ADDRESS_I == `VPIC_OFS_GCTL1;
	wire        hit_g2    = AVS_ADDRESS_I == `VPIC_OFS_GCTL2;
	wire        hit_sr    = AVS_ADDRESS_I == `VPIC_OFS_STATUS;
	wire        hit_core  = AVS_ADDRESS_I == `VPIC_OFS_CORE;
	wire        hit_snap  = AVS_ADDRESS_I == `VPIC_OFS_SNAP;
	wire [5:0]  flag_base = 6'(`VPIC_OFS_FLAG0 >> 2);
	wire [5:0]  enab_base = 6'(`VPIC_OFS_ENAB0 >> 2);
	wire [2:0]  flag_sel  = 3'(word_idx - flag_base);
	wire [2:0]  enab_sel  = 3'(word_idx - enab_base);
	wire        hit_flag  = (word_idx >= flag_base) && (word_idx < flag_base + 6'(`VPIC_NUM_FLAG_REGS))
		&& (AVS_ADDRESS_I[1:0] == 2'h0);
	wire        hit_enab  = (word_idx >= enab_base) && (word_idx < enab_base + 6'(`VPIC_NUM_FLAG_REGS))
		&& (AVS_ADDRESS_I[1:0] == 2'h0);
	wire        prio_hole = (prio_idx == `VPIC_PRIO_HOLE_A) || (prio_idx == `VPIC_PRIO_HOLE_B)
		|| (prio_idx == `VPIC_PRIO_HOLE_C);
	wire        hit_prio  = AVS_ADDRESS_I[7] && (AVS_ADDRESS_I[1:0] == 2'h0)
		&& (prio_idx < 5'(`VPIC_NUM_PRIO_REGS)) && !prio_hole;

	// wait one cycle on every request, then answer
	assign AVS_WAITREQUEST_O = bus_req & ~ack_q;
	assign AVS_READDATA_O    = rdata_q;

	// synced pins: edge per pin, direction from polarity
	wire [2:0] pin_rise = pin_s_q & ~pin_p_q;
	wire [2:0] pin_fall = ~pin_s_q & pin_p_q;
	wire [2:0] pin_edge = (edge_pol_q & pin_fall) | (~edge_pol_q & pin_rise);

	// flat views for the arbiter; vector n is bit n
	logic [`VPIC_NUM_SRC-1:0]   flag_flat;
	logic [`VPIC_NUM_SRC-1:0]   enab_flat;
	logic [`VPIC_NUM_SRC*3-1:0] prio_flat;
	logic [`VPIC_NUM_SRC-1:0]   set_flat;
	always_comb begin
		for (int r = 0; r < `VPIC_NUM_FLAG_REGS; r++) begin
			flag_flat[r*16 +: 16] = flag_q[r];
			enab_flat[r*16 +: 16] = enab_q[r];
		end
		// field k of register r is vector 4r+k, bits 4k+2:4k
		for (int s = 0; s < `VPIC_NUM_SRC; s++) begin
			prio_flat[s*3 +: 3] = prio_q[s/4][(s%4)*4 +: 3];
		end
		set_flat = SRC_EVENT_I;
		set_flat[`VPIC_EXT0_VEC] = SRC_EVENT_I[`VPIC_EXT0_VEC] | pin_edge[0];
		set_flat[`VPIC_EXT1_VEC] = SRC_EVENT_I[`VPIC_EXT1_VEC] | pin_edge[1];
		set_flat[`VPIC_EXT2_VEC] = SRC_EVENT_I[`VPIC_EXT2_VEC] | pin_edge[2];
	end

	// arbitration against the full four-bit level
	logic                 win_found;
	vpic_pkg::vpic_vec_t  win_vec;
	vpic_pkg::vpic_prio_t win_prio;
	wire vpic_pkg::vpic_level_t cur_level = {top_q, level_q};
	vpic_arbiter u_arb (
		.pend_i  (flag_flat),
		.enab_i  (enab_flat),
		.prio_i  (prio_flat),
		.level_i (cur_level),
		.found_o (win_found),
		.vec_o   (win_vec),
		.prio_o  (win_prio)
	);

	// read mux, unmapped reads return zero
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		if (hit_g1) begin
			rd_mux = {nest_dis_q, 10'h000, trap_q, 1'b0};
		end else if (hit_g2) begin
			rd_mux = {alt_sel_q, 12'h000, edge_pol_q};
		end else if (hit_sr) begin
			rd_mux = {8'h00, level_q, 5'h00};
		end else if (hit_core) begin
			rd_mux = {12'h000, top_q, 3'h0};
		end else if (hit_snap) begin
			rd_mux = {4'h0, snap_lvl_q, 1'b0, snap_vec_q};
		end else if (hit_flag) begin
			rd_mux = flag_q[flag_sel];
		end else if (hit_enab) begin
			rd_mux = enab_q[enab_sel];
		end else if (hit_prio) begin
			rd_mux = prio_q[prio_idx];
		end
	end

	// bus handshake and read capture
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= bus_req & ~ack_q;
			rdata_q <= {16'h0000, rd_mux};
		end
	end

	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pin_m_q <= 3'h0;
			pin_s_q <= 3'h0;
			pin_p_q <= 3'h0;
		end else begin
			pin_m_q <= EXT_PIN_I;
			pin_s_q <= pin_m_q;
			pin_p_q <= pin_s_q;
		end
	end

	// flags: software writes value, hardware set wins same cycle
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int r = 0; r < `VPIC_NUM_FLAG_REGS; r++) begin
				flag_q[r] <= `VPIC_RST_WORD;
				enab_q[r] <= `VPIC_RST_WORD;
			end
		end else begin
			for (int r = 0; r < `VPIC_NUM_FLAG_REGS; r++) begin
				flag_q[r] <= ((wr_go && hit_flag && flag_sel == 3'(r))
					? merge16(flag_q[r], AVS_WRITEDATA_I, AVS_BYTEENABLE_I) : flag_q[r])
					| set_flat[r*16 +: 16];
				if (wr_go && hit_enab && enab_sel == 3'(r)) begin
					enab_q[r] <= merge16(enab_q[r], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				end
			end
		end
	end

	// priority registers, unused bits held at zero
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int r = 0; r < `VPIC_NUM_PRIO_REGS; r++) begin
				prio_q[r] <= `VPIC_RST_WORD;
			end
		end else if (wr_go && hit_prio) begin
			prio_q[prio_idx] <= merge16(prio_q[prio_idx], AVS_WRITEDATA_I, AVS_BYTEENABLE_I)
				& `VPIC_PRIO_MASK;
		end
	end

	// global controls; trap flags set by hardware, set wins
	wire [15:0] g1_wr = merge16({nest_dis_q, 10'h000, trap_q, 1'b0}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	wire [15:0] g2_wr = merge16({alt_sel_q, 12'h000, edge_pol_q}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			nest_dis_q <= 1'b0;
			trap_q     <= 4'h0;
			alt_sel_q  <= 1'b0;
			edge_pol_q <= 3'h0;
		end else begin
			// control one holds nesting and traps
			if (wr_go && hit_g1) begin
				nest_dis_q <= g1_wr[`VPIC_NEST_DIS_BIT];
				trap_q     <= g1_wr[`VPIC_TRAP_LSB +: 4] | TRAP_EVENT_I;
			end else begin
				trap_q     <= trap_q | TRAP_EVENT_I;
			end
			// control two holds edges and table
			if (wr_go && hit_g2) begin
				alt_sel_q  <= g2_wr[`VPIC_ALT_SEL_BIT];
				edge_pol_q <= g2_wr[2:0];
			end
		end
	end

	// cpu level: taken request raises it, software may move it unless nesting is disabled
	wire [15:0] sr_wr   = merge16({8'h00, level_q, 5'h00}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	wire [15:0] core_wr = merge16({12'h000, top_q, 3'h0}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
	wire        take    = IRQ_ACK_I & req_q;
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			level_q    <= `VPIC_RST_LEVEL;
			top_q      <= 1'b0;
			snap_vec_q <= 7'h00;
			snap_lvl_q <= 4'h0;
		end else begin
			if (take) begin
				level_q    <= win_prio_q;
				snap_vec_q <= vec_q;
				snap_lvl_q <= {top_q, win_prio_q};
			end else if (wr_go && hit_sr && !nest_dis_q) begin
				level_q <= sr_wr[`VPIC_LEVEL_LSB +: 3];
			end
			if (TRAP_ENTER_I) begin
				top_q <= 1'b1;
			end else if (wr_go && hit_core && !core_wr[`VPIC_TOP_BIT]) begin
				top_q <= 1'b0;
			end
		end
	end

	// registered request toward the cpu
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			req_q      <= 1'b0;
			vec_q      <= 7'h00;
			win_prio_q <= 3'h0;
			fetch_q    <= 24'h000000;
		end else begin
			// level 7 leaves no field above it
			// raise only for an eligible winner
			req_q      <= win_found & ~take;
			vec_q      <= win_vec;
			win_prio_q <= win_prio;
			fetch_q    <= vec_addr(win_vec, alt_sel_q);
		end
	end

	// outputs
	assign IRQ_REQ_O        = req_q;
	assign IRQ_VECTOR_O     = vec_q;
	assign IRQ_PRIO_O       = win_prio_q;
	assign IRQ_FETCH_ADDR_O = fetch_q;
	assign CPU_LEVEL_O      = cur_level;
endmodule

// ### bench/vpic_ctrl_props.sv
`timescale 1ns/1ps
// port-level checks of the controller, bound below
module vpic_ctrl_props (
	input wire logic                   SYS_CLK_I,
	input wire logic                   RESET_N_I,
	input wire logic                   AVS_READ_I,
	input wire logic                   AVS_WRITE_I,
	input wire logic                   AVS_WAITREQUEST_O,
	input wire logic                   TRAP_ENTER_I,
	input wire logic                   IRQ_ACK_I,
	input wire logic                   IRQ_REQ_O,
	input wire vpic_pkg::vpic_vec_t    IRQ_VECTOR_O,
	input wire vpic_pkg::vpic_prio_t   IRQ_PRIO_O,
	input wire vpic_pkg::vpic_addr_t   IRQ_FETCH_ADDR_O,
	input wire vpic_pkg::vpic_level_t  CPU_LEVEL_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	wire bus_req = AVS_READ_I | AVS_WRITE_I; // any bus request
	wire [23:0] prim = 24'h14 + {IRQ_VECTOR_O, 1'b0}; // primary entry
	// the cpu takes the standing request
	sequence s_take;
		IRQ_REQ_O && IRQ_ACK_I;
	endsequence
	a_wait_once: assert property (bus_req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("more than one wait cycle");
	a_idle_ready: assert property (!bus_req |-> !AVS_WAITREQUEST_O)
		else $error("wait without request");
	a_take_drop: assert property (s_take |=> !IRQ_REQ_O)
		else $error("request stands after take");
	a_take_level: assert property (s_take |=> CPU_LEVEL_O[2:0] == $past(IRQ_PRIO_O))
		else $error("level not updated on take");
	a_req_above: assert property (IRQ_REQ_O && $stable(CPU_LEVEL_O) |-> {1'b0, IRQ_PRIO_O} > CPU_LEVEL_O)
		else $error("request not above cpu level");
	a_level_block: assert property (CPU_LEVEL_O[2:0] == 3'h7 && $stable(CPU_LEVEL_O) |-> !IRQ_REQ_O)
		else $error("request at level seven");
	a_zero_prio: assert property (IRQ_REQ_O |-> IRQ_PRIO_O != 3'h0)
		else $error("zero priority requests");
	a_top_cause: assert property ($rose(CPU_LEVEL_O[3]) |-> $past(TRAP_ENTER_I))
		else $error("top bit set without trap entry");
	a_fetch_addr: assert property (IRQ_REQ_O |-> IRQ_FETCH_ADDR_O == prim || IRQ_FETCH_ADDR_O == prim + 24'h100)
		else $error("fetch address wrong");
endmodule
bind vpic_ctrl vpic_ctrl_props vpic_ctrl_props_i (.SYS_CLK_I, .RESET_N_I, .AVS_READ_I, .AVS_WRITE_I,
	.AVS_WAITREQUEST_O, .TRAP_ENTER_I, .IRQ_ACK_I, .IRQ_REQ_O, .IRQ_VECTOR_O, .IRQ_PRIO_O,
	.IRQ_FETCH_ADDR_O, .CPU_LEVEL_O);

// ### bench/vpic_cpu_model.sv
`timescale 1ns/1ps
// cpu stand-in: takes the request after lat_i cycles
module vpic_cpu_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        req_i,
	input  wire logic [3:0]  lat_i,
	output logic             ack_o
);
	logic [3:0] cnt_q; // cycles the request has stood
	logic       ack_q; // one-cycle take pulse
	assign ack_o = ack_q;
	// pulse only while the request stands, never twice in a row
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
		end else begin
			ack_q <= req_i && !ack_q && cnt_q >= lat_i;
			cnt_q <= (req_i && !ack_q && cnt_q < lat_i) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule

// ### bench/vpic_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "vpic_cfg.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module vpic_ctrl_tb_top;
	logic        sys_clk;
	logic        reset_n;
	logic [7:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        wreq;
	logic [79:0] evt;
	logic [2:0]  pin;
	logic [3:0]  trap;
	logic        tenter;
	logic        req;
	logic        ack;
	logic [3:0]  lat;
	logic [23:0] faddr;
	logic [31:0] e32;
	logic [23:0] e24;
	logic [6:0]  e7;
	logic [6:0]  vec;
	int          compares;
	int          fail_count;
	int          seed;
	logic [15:0] rq[$]; // expected read data, oldest first
	logic [23:0] iq[$]; // expected fetch addresses of takes
	logic [6:0]  vq[$]; // expected vectors of takes
	logic [7:0]  offs[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h40, 8'h80, 8'hB4, 8'hC4};
	vpic_ctrl vpic_ctrl_i (.SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'h3),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .SRC_EVENT_I(evt), .EXT_PIN_I(pin),
		.TRAP_EVENT_I(trap), .TRAP_ENTER_I(tenter), .IRQ_ACK_I(ack), .IRQ_REQ_O(req),
		.IRQ_VECTOR_O(vec), .IRQ_PRIO_O(), .IRQ_FETCH_ADDR_O(faddr), .CPU_LEVEL_O());
	vpic_cpu_model vpic_cpu_model_i (.clk_i(sys_clk), .rst_n_i(reset_n), .req_i(req), .lat_i(lat), .ack_o(ack));
	// free-running 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// one bus transfer; for a read d is the expected value
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		if (!w) rq.push_back(d);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= {16'h0, d};
		// hold everything until a rising edge samples waitrequest low
		@(posedge sys_clk);
		while (wreq !== 1'b0) @(posedge sys_clk);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	// one-cycle peripheral pulse
	task automatic ev(input logic [79:0] m);
		evt <= m;
		@(posedge sys_clk);
		evt <= '0;
		@(posedge sys_clk);
	endtask
	// bounded wait until every queued take was seen
	task automatic wait_take();
		for (int i = 0; i < 40 && iq.size() > 0; i++) @(posedge sys_clk);
		if (iq.size() > 0) begin
			fail_count++;
			$display("BAD take exp %h got none", iq[0]);
			iq.delete();
			vq.delete();
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// results are checked at the rising edge where they stand, against the oldest note
	always @(posedge sys_clk) begin
		if (rd && !wreq) begin
			e32 = {16'h0, rq.pop_front()};
			`CHK("rdata", e32, rdat)
		end
		// a take with nothing expected is an error of its own
		if (req && ack) begin
			if (iq.size() == 0) begin
				fail_count++;
				$display("BAD take exp none got %h", faddr);
			end else begin
				e24 = iq.pop_front();
				e7 = vq.pop_front();
				`CHK("fetch", e24, faddr)
				`CHK("vector", e7, vec)
			end
		end
	end
	// cut a hang short
	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		conclude();
	end
	initial begin
		logic [15:0] d;
		seed = 32'hf1e9;
		compares = 0;
		fail_count = 0;
		{rd, wr, adr, wdat, evt, pin, trap, tenter, lat, reset_n} = '0;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		foreach (offs[i]) acc(1'b0, offs[i], 16'h0);
		acc(1'b1, 8'hB8, 16'hFFFF);
		acc(1'b0, 8'hB8, 16'h0);
		$display("test reset done");
		for (int r = 0; r < 21; r++) if (r != 13 && r != 14 && r != 17) begin
			d = 16'($random(seed));
			acc(1'b1, 8'h80 + 8'(4 * r), d);
			acc(1'b0, 8'h80 + 8'(4 * r), d & `VPIC_PRIO_MASK);
			acc(1'b1, 8'h80 + 8'(4 * r), 16'h0);
		end
		$display("test priority fields done");
		acc(1'b1, 8'h0C, 16'h0008);
		acc(1'b0, 8'h0C, 16'h0);
		tenter <= 1'b1;
		trap <= 4'hF;
		@(posedge sys_clk);
		tenter <= 1'b0;
		trap <= 4'h0;
		@(posedge sys_clk);
		acc(1'b0, 8'h0C, 16'h0008);
		acc(1'b0, 8'h00, 16'h001E);
		acc(1'b1, 8'h0C, 16'h0);
		acc(1'b1, 8'h00, 16'h0);
		acc(1'b0, 8'h0C, 16'h0);
		acc(1'b1, 8'h08, 16'h00E0);
		acc(1'b0, 8'h08, 16'h00E0);
		acc(1'b1, 8'h00, 16'h8000);
		acc(1'b1, 8'h08, 16'h0);
		acc(1'b0, 8'h08, 16'h00E0);
		acc(1'b1, 8'h00, 16'h0);
		acc(1'b1, 8'h08, 16'h0);
		acc(1'b0, 8'h08, 16'h0);
		$display("test level bits done");
		// vec1 prio 0, vec2 prio 5 disabled, vec5 and vec6 tie at 3
		acc(1'b1, 8'h80, 16'h0500);
		acc(1'b1, 8'h84, 16'h0330);
		acc(1'b1, 8'h40, 16'h0062);
		iq.push_back(24'h00001E);
		vq.push_back(7'h05);
		ev(80'h66);
		wait_take();
		acc(1'b0, 8'h20, 16'h0066);
		acc(1'b0, 8'h10, 16'h0305);
		acc(1'b1, 8'h04, 16'h8000);
		lat <= 4'h5;
		acc(1'b1, 8'h20, 16'h0040);
		iq.push_back(24'h000120);
		vq.push_back(7'h06);
		acc(1'b1, 8'h08, 16'h0);
		wait_take();
		acc(1'b0, 8'h10, 16'h0306);
		// level seven first, then raise the pending source to seven: nothing may be taken
		acc(1'b1, 8'h08, 16'h00E0);
		acc(1'b1, 8'h84, 16'h0730);
		repeat (10) @(posedge sys_clk);
		acc(1'b0, 8'h10, 16'h0306);
		acc(1'b1, 8'h20, 16'h0);
		acc(1'b1, 8'h04, 16'h0);
		$display("test arbitration done");
		pin <= 3'h1;
		repeat (5) @(posedge sys_clk);
		acc(1'b0, 8'h20, 16'h0001);
		acc(1'b1, 8'h20, 16'h0);
		acc(1'b1, 8'h04, 16'h0001);
		pin <= 3'h0;
		repeat (5) @(posedge sys_clk);
		acc(1'b0, 8'h20, 16'h0001);
		acc(1'b1, 8'h20, 16'h0);
		pin <= 3'h1;
		repeat (5) @(posedge sys_clk);
		acc(1'b0, 8'h20, 16'h0);
		$display("test pin polarity done");
		conclude();
	end
endmodule
